// ==== dv/far_side_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module far_side_model
(
  input wire logic mclk,
  output logic subClock,
  output logic eventPinA,
  output logic eventPinB,
  output logic comparatorDebouncedOut,
  output logic comparatorPulseOut,
  output logic pulseGenOutput,
  output logic pulseGenDisable
);
  int div = 0;

  // quiet levels at time zero
  initial
  begin
    subClock = 1'b0;
    eventPinA = 1'b0;
    eventPinB = 1'b0;
    comparatorDebouncedOut = 1'b0;
    comparatorPulseOut = 1'b0;
    pulseGenOutput = 1'b0;
    pulseGenDisable = 1'b0;
  end

  // sub clock of sixteen mclk periods
  always @(posedge mclk)
  begin
    div <= (div + 1) % 8;
    if (div == 7)
      subClock <= ~subClock;
  end

  // pin change, then time for the synchroniser to settle
  task automatic setB(input logic lvl);
    @(posedge mclk);
    eventPinB <= lvl;
    repeat (8) @(posedge mclk);
  endtask : setB
endmodule : far_side_model

`default_nettype wire

// ==== dv/timer_event_counter_set_test.sv ====
`timescale 1ns/10ps
`default_nettype none

module timer_event_counter_set_test;
  import timer_set_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [3:0] wstrb = 4'hF, overflowRequest;
  logic [1:0] bresp, rresp, gotResp;
  logic awready, wready, bvalid, arready, rvalid, triggerBlock, pulseGenRetrigger;
  logic subClock, eventPinA, eventPinB, comparatorDebouncedOut, comparatorPulseOut;
  logic pulseGenOutput, pulseGenDisable;
  int mismatches = 0, samples_checked = 0, ovf1 = 0, seed = 48, cnt, n, i, e;
  int rst [10] = '{0, 8, 0, 8, 0, 0, 0, 8, 0, 0};
  int psc [5] = '{4, 5, 6, 7, 0};
  int rate [5] = '{2, 0, 1, 0, 0};
  int tick [5] = '{65, 65, 65, 16, 0};

  timer_event_counter_set dut_u (.mclk(mclk), .reset(reset), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .subClock(subClock), .eventPinA(eventPinA), .eventPinB(eventPinB),
    .comparatorDebouncedOut(comparatorDebouncedOut), .comparatorPulseOut(comparatorPulseOut),
    .pulseGenOutput(pulseGenOutput), .pulseGenDisable(pulseGenDisable),
    .overflowRequest(overflowRequest), .triggerBlock(triggerBlock),
    .pulseGenRetrigger(pulseGenRetrigger));

  far_side_model partner_u (.mclk(mclk), .subClock(subClock), .eventPinA(eventPinA),
    .eventPinB(eventPinB), .comparatorDebouncedOut(comparatorDebouncedOut),
    .comparatorPulseOut(comparatorPulseOut), .pulseGenOutput(pulseGenOutput),
    .pulseGenDisable(pulseGenDisable));

  always #12.5 mclk = ~mclk;

  // overflow pulses seen on counter 1
  always @(posedge mclk)
    if (overflowRequest[1] === 1'b1)
      ovf1 <= ovf1 + 1;

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic bound(input int k);
    if (k >= 64)
    begin
      mismatches++;
      summarize();
    end
  endtask : bound

  // compare with an allowed slack
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input int tol = 0);
    samples_checked++;
    if ((g - x <= tol) !== 1'b1 && (x - g <= tol) !== 1'b1)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  // one bus write, address and data offered together
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int k;
    bit done;
    k = 0;
    done = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && k < 64)
    begin
      @(posedge mclk);
      k++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        gotResp = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    bound(k);
    @(posedge mclk);
  endtask : wr

  // one bus read
  task automatic rd(input logic [5:0] a);
    int k;
    bit done;
    k = 0;
    done = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && k < 64)
    begin
      @(posedge mclk);
      k++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        got = rdata;
        gotResp = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    bound(k);
    @(posedge mclk);
  endtask : rd

  // main sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 10; i++)
    begin
      rd(6'(i * 4));
      chk(got, rst[i]);
    end
    rd(6'h28);
    chk(gotResp, RESP_SLVERR);
    wr(6'h28, 8'h55);
    chk(gotResp, RESP_SLVERR);
    $display("test registers done");
    wr(ADDR_COUNTER2_CONTROL, 8'hFF);
    rd(ADDR_COUNTER2_CONTROL);
    chk(got, 8'hD7);
    wr(ADDR_COUNTER2_CONTROL, 8'h50);
    repeat (2) @(posedge mclk);
    chk(triggerBlock, 1);
    wr(ADDR_COUNTER2_CONTROL, 8'h90);
    repeat (2) @(posedge mclk);
    chk(triggerBlock, 0);
    $display("test counter2 done");
    for (i = 0; i < 5; i++)
    begin
      wr(ADDR_PRESCALER_CONTROL, 8'(psc[i]));
      rd(ADDR_PRESCALER_CONTROL);
      chk(got, psc[i]);
      wr(ADDR_COUNTER0_CONTROL, 8'(8'h80 + rate[i]));
      wr(ADDR_COUNTER0_VALUE, 8'h00);
      wr(ADDR_COUNTER0_CONTROL, 8'(8'h90 + rate[i]));
      repeat (256) @(posedge mclk);
      wr(ADDR_COUNTER0_CONTROL, 8'(8'h80 + rate[i]));
      rd(ADDR_COUNTER0_VALUE);
      chk(got, tick[i], 2);
    end
    $display("test timer rates done");
    wr(ADDR_COUNTER1_CONTROL, 8'h40);
    wr(ADDR_COUNTER1_VALUE, 8'hFD);
    cnt = 8'hFD;
    partner_u.setB(1'b1);
    partner_u.setB(1'b0);
    rd(ADDR_COUNTER1_VALUE);
    chk(got, cnt);
    wr(ADDR_COUNTER1_CONTROL, 8'h50);
    wr(ADDR_COUNTER1_VALUE, 8'h10);
    rd(ADDR_COUNTER1_VALUE);
    chk(got, cnt);
    for (e = 0; e < 2; e++)
    begin
      wr(ADDR_COUNTER1_CONTROL, 8'(8'h50 + e * 8));
      for (n = 1; n >= 0; n--)
      begin
        partner_u.setB(n[0]);
        if (n == 1 - e)
          cnt++;
        rd(ADDR_COUNTER1_VALUE);
        chk(got, cnt);
      end
    end
    n = ($random(seed) & 3) + 2;
    for (i = 0; i < n; i++)
    begin
      partner_u.setB(1'b1);
      partner_u.setB(1'b0);
      cnt = (cnt == 255) ? 8'h10 : cnt + 1;
    end
    rd(ADDR_COUNTER1_VALUE);
    chk(got, cnt);
    chk(ovf1, 1);
    $display("test event counter done");
    wr(ADDR_PRESCALER_CONTROL, 8'h04);
    wr(ADDR_COUNTER1_CONTROL, 8'hC8);
    wr(ADDR_COUNTER1_VALUE, 8'h00);
    wr(ADDR_COUNTER1_CONTROL, 8'hD8);
    wr(ADDR_COUNTER1_CONTROL, 8'hD0);
    wr(ADDR_COUNTER1_CONTROL, 8'hC0);
    rd(ADDR_COUNTER1_VALUE);
    chk(got, 4, 1);
    wr(ADDR_COUNTER3_CONTROL_B, 8'h01);
    wr(ADDR_COUNTER3_VALUE, 8'hF0);
    wr(ADDR_COUNTER3_CONTROL_A, 8'h10);
    repeat (8) @(posedge mclk);
    rd(ADDR_COUNTER3_VALUE);
    chk(got, 8'hF0);
    $display("test pulse width and generator gate done");
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(ADDR_COUNTER1_VALUE);
    chk(got, 0);
    $display("test second reset done");
    summarize();
  end
endmodule : timer_event_counter_set_test

`default_nettype wire

// ==== dv/timer_set_props.sv ====
`timescale 1ns/10ps
`default_nettype none

module timer_set_props
  import timer_set_pkg::*;
#(
  parameter int COUNTERS = 4,
  parameter int DIVIDER_WIDTH = 7
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [3:0] overflowRequest,
  input wire logic triggerBlock,
  input wire logic pulseGenRetrigger
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (reset);

  // read channel answers
  a_read_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_rdata_byte: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_read_unmapped: assert property (arvalid && arready && araddr > ADDR_COUNTER3_VALUE
    |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  // write channel answers
  a_write_latency: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  a_write_unmapped: assert property (awvalid && awready && wvalid && wready
    && awaddr > ADDR_COUNTER3_VALUE |-> ##2 bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_aw_closed: assert property (awvalid && awready |=> !awready)
    else $error("address taken twice");
  // reset clears every request line
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !bvalid && !rvalid
    && overflowRequest == 4'h0 && !triggerBlock)
    else $error("outputs busy after reset");

  // retrigger only comes with a counter 3 overflow
  a_retrig_overflow: assert property (pulseGenRetrigger |-> overflowRequest[3])
    else $error("retrigger without overflow");

  c_overflow: cover property (overflowRequest[1]);
  c_block: cover property ($rose(triggerBlock));
  c_read_err: cover property (rvalid && rresp == RESP_SLVERR);
  c_write_err: cover property (bvalid && bresp == RESP_SLVERR);
endmodule : timer_set_props

bind timer_event_counter_set timer_set_props #(.COUNTERS(COUNTERS),
  .DIVIDER_WIDTH(DIVIDER_WIDTH)) props_u (.mclk(mclk), .reset(reset), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .overflowRequest(overflowRequest), .triggerBlock(triggerBlock),
  .pulseGenRetrigger(pulseGenRetrigger));

`default_nettype wire

// ==== rtl/timer_event_counter_set.sv ====
// Overview of operation
// - four independent 8-bit counters that only count upward.
// - counters 0 and 1 offer timer, event counting and pulse width modes.
// - counter 2 offers timer and a non-retriggering pulse generator mode.
// - counter 3 offers timer, event, pulse width and retriggering pulse generator modes.
// - counters 0, 1, 3 take internal or external clock; counter 2 internal only.
// - source field picks sys, sys/4, sys/2 or sub clock for the prescaler.
// - prescaler gate bit stops the prescaler clock when low.
// - each counter divides the prescaler clock by its own rate field.
// - external source bit picks the per-counter pin or comparator signal; counter 3 picks debounced or pulse comparator.
// - comparator pulse cannot gate pulse width and ignores edge select in event mode.
// - value increments on each internal tick or active external transition.
// - at FFH the counter overflows, requests an interrupt and reloads preload.
// - preload write while stopped also loads the counter at once.
// - preload write while running waits for the next overflow.
// - reading a value register returns the live count, not the preload.
// - counter 2 drives a trigger block signal to the pulse generator.
// - counter 3 drives retrigger and takes pulse generator output and disable.
// - rate codes 000 to 111 divide by 1, 2, 4 up to 128.
// - mode codes: 00 none, 01 event, 10 timer, 11 pulse width.
// - run bit high lets the counter run, low stops it.
// - edge select: event rising/falling; pulse width low-gated or high-gated.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module timer_event_counter_set
  import timer_set_pkg::*;
#(
  parameter int COUNTERS = 4,
  parameter int DIVIDER_WIDTH = 7
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic subClock,
  input wire logic eventPinA,
  input wire logic eventPinB,
  input wire logic comparatorDebouncedOut,
  input wire logic comparatorPulseOut,
  input wire logic pulseGenOutput,
  input wire logic pulseGenDisable,
  output logic [3:0] overflowRequest,
  output logic triggerBlock,
  output logic pulseGenRetrigger
);

  if (COUNTERS != 4 || DIVIDER_WIDTH != 7)
  begin : g_check
    $error("timer_event_counter_set serves four counters and a 7-bit divider only");
  end

  typedef logic [DIVIDER_WIDTH-1:0] divider_t;

  typedef struct packed {
    logic [2:0] prescalerControl;
    logic [3:0][7:0] control;
    logic [7:0] control3b;
    logic [3:0][7:0] preload;
    logic [3:0][7:0] count;
    logic [3:0][DIVIDER_WIDTH-1:0] divider;
    logic [1:0] sysDivider;
    logic [1:0] subSync;
    logic subPrev;
    logic [1:0] pinASync;
    logic [1:0] pinBSync;
    logic [1:0] debSync;
    logic pinAPrev;
    logic pinBPrev;
    logic debPrev;
    logic pulsePrev;
    logic awHeld;
    logic [5:0] awAddrHeld;
    logic wHeld;
    logic [7:0] wDataHeld;
    logic wLaneHeld;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [3:0] overflowRequest;
    logic triggerBlock;
    logic pulseGenRetrigger;
  } state_s;

  state_s st;
  state_s next_st;

  // register index 0..9 from a byte address, 15 when unmapped
  function automatic logic [3:0] regIndex(input logic [5:0] addr);
    logic [3:0] idx;
    idx = 4'hF;
    unique case (addr)
      ADDR_PRESCALER_CONTROL: idx = 4'h0;
      ADDR_COUNTER0_CONTROL: idx = 4'h1;
      ADDR_COUNTER0_VALUE: idx = 4'h2;
      ADDR_COUNTER1_CONTROL: idx = 4'h3;
      ADDR_COUNTER1_VALUE: idx = 4'h4;
      ADDR_COUNTER2_CONTROL: idx = 4'h5;
      ADDR_COUNTER2_VALUE: idx = 4'h6;
      ADDR_COUNTER3_CONTROL_A: idx = 4'h7;
      ADDR_COUNTER3_CONTROL_B: idx = 4'h8;
      ADDR_COUNTER3_VALUE: idx = 4'h9;
      default: idx = 4'hF;
    endcase
    return idx;
  endfunction : regIndex

  // tick when the low rate bits of the divider are all ones
  function automatic logic rateTick(input divider_t div, input logic [2:0] rate);
    divider_t mask;
    mask = '0;
    for (int i = 0; i < DIVIDER_WIDTH; i++)
    begin
      mask[i] = (3'(i) < rate);
    end
    return (div & mask) == mask;
  endfunction : rateTick

  // whole next state of the block
  always_comb
  begin
    logic prescaleTick;
    logic [3:0] idx;
    logic doWrite;
    logic [1:0] mode;
    logic run;
    logic edgeSel;
    logic extSel;
    logic usesPulse;
    logic cur;
    logic prev;
    logic rise;
    logic fall;
    logic internalTick;
    logic countPulse;
    logic ppgMode;
    logic [3:0] ctlIdx;
    logic [3:0] valIdx;
    prescaleTick = 1'b0;
    idx = 4'hF;
    doWrite = 1'b0;
    mode = MODE_NONE;
    run = 1'b0;
    edgeSel = 1'b0;
    extSel = 1'b0;
    usesPulse = 1'b0;
    cur = 1'b0;
    prev = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    internalTick = 1'b0;
    countPulse = 1'b0;
    ppgMode = 1'b0;
    ctlIdx = 4'hF;
    valIdx = 4'hF;
    next_st = st;

    // two-stage synchronisers and edge history
    next_st.subSync = {st.subSync[0], subClock};
    next_st.pinASync = {st.pinASync[0], eventPinA};
    next_st.pinBSync = {st.pinBSync[0], eventPinB};
    next_st.debSync = {st.debSync[0], comparatorDebouncedOut};
    next_st.subPrev = st.subSync[1];
    next_st.pinAPrev = st.pinASync[1];
    next_st.pinBPrev = st.pinBSync[1];
    next_st.debPrev = st.debSync[1];
    next_st.pulsePrev = comparatorPulseOut;
    next_st.sysDivider = st.sysDivider + 2'h1;

    unique case (st.prescalerControl[PRESCALE_SOURCE_LSB +: 2])
      SOURCE_SYS: prescaleTick = 1'b1;
      SOURCE_SYS_DIV4: prescaleTick = (st.sysDivider == 2'h3);
      SOURCE_SYS_DIV2: prescaleTick = st.sysDivider[0];
      SOURCE_SUB: prescaleTick = st.subSync[1] & ~st.subPrev;
    endcase
    prescaleTick = prescaleTick & st.prescalerControl[PRESCALE_GATE_BIT];

    next_st.overflowRequest = 4'h0;
    next_st.pulseGenRetrigger = 1'b0;

    // per-counter clocking and counting
    for (int n = 0; n < 4; n++)
    begin
      mode = st.control[n][MODE_LSB +: 2];
      run = st.control[n][RUN_BIT];
      edgeSel = st.control[n][EDGE_SELECT_BIT];
      extSel = st.control[n][EXT_SOURCE_BIT];
      usesPulse = (n == 1 || n == 3) && extSel;
      cur = (n == 0) ? (extSel ? st.debSync[1] : st.pinASync[1]) :
        (n == 1) ? (extSel ? comparatorPulseOut : st.pinBSync[1]) :
        (n == 3) ? (extSel ? comparatorPulseOut : st.debSync[1]) : 1'b0;
      prev = (n == 0) ? (extSel ? st.debPrev : st.pinAPrev) :
        (n == 1) ? (extSel ? st.pulsePrev : st.pinBPrev) :
        (n == 3) ? (extSel ? st.pulsePrev : st.debPrev) : 1'b0;
      rise = cur & ~prev;
      fall = ~cur & prev;
      // per-counter divider, divide by two to the rate
      internalTick = run & prescaleTick &
        rateTick(st.divider[n], st.control[n][RATE_LSB +: 3]);
      // divider restarts whenever the counter is stopped
      next_st.divider[n] = !run ? '0 :
        (prescaleTick ? st.divider[n] + divider_t'(1) : st.divider[n]);
      // counter 2 pulse generator mode uses the event code
      // counter 3 pulse generator mode is code none with retrigger option
      ppgMode = (n == 2 && mode == MODE_EVENT) ||
        (n == 3 && mode == MODE_NONE && st.control3b[RETRIGGER_OPTION_BIT]);
      countPulse = 1'b0;
      // mode decode, counter 2 has no external source
      if (ppgMode)
      begin
        // counter 3 counts while the generator output is live
        countPulse = internalTick & ((n != 3) | (pulseGenOutput & ~pulseGenDisable));
      end
      else
      begin
        unique case (mode)
          MODE_TIMER: countPulse = internalTick;
          // pulse source ignores edge select; edge choice
          MODE_EVENT: countPulse = (n != 2) & run & (usesPulse ? rise : (edgeSel ? fall : rise));
          // pulse source cannot gate; level gate by edge select
          MODE_PULSE_WIDTH: countPulse = (n != 2) & !usesPulse & internalTick &
            (edgeSel ? cur : ~cur);
          MODE_NONE: countPulse = 1'b0;
        endcase
      end
      if (countPulse && run)
      begin
        if (st.count[n] == COUNT_FULL)
        begin
          next_st.count[n] = st.preload[n];
          next_st.overflowRequest[n] = 1'b1;
          if (n == 3 && ppgMode)
          begin
            next_st.pulseGenRetrigger = 1'b1;
          end
        end
        else
        begin
          next_st.count[n] = st.count[n] + 8'h01;
        end
      end
    end

    // block further triggers while counter 2 runs its generator mode
    next_st.triggerBlock = st.control[2][RUN_BIT] &&
      (st.control[2][MODE_LSB +: 2] == MODE_EVENT);

    // bus write channel capture
    if (awvalid && st.awready)
    begin
      next_st.awHeld = 1'b1;
      next_st.awAddrHeld = awaddr;
    end
    if (wvalid && st.wready)
    begin
      next_st.wHeld = 1'b1;
      next_st.wDataHeld = wdata[7:0];
      next_st.wLaneHeld = wstrb[0];
    end
    if (bvalid && bready)
    begin
      next_st.bvalid = 1'b0;
    end

    // register write once address and data are both held
    doWrite = st.awHeld && st.wHeld && !st.bvalid;
    if (doWrite)
    begin
      idx = regIndex(st.awAddrHeld);
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = (idx == 4'hF) ? RESP_SLVERR : RESP_OKAY;
      if (st.wLaneHeld)
      begin
        unique case (idx)
          4'h0: next_st.prescalerControl = st.wDataHeld[2:0];
          4'h1, 4'h3, 4'h7:
          begin
            ctlIdx = (idx == 4'h1) ? 4'h0 : ((idx == 4'h3) ? 4'h1 : 4'h3);
            next_st.control[ctlIdx[1:0]] = st.wDataHeld;
          end
          4'h5: next_st.control[2] = st.wDataHeld & COUNTER2_CONTROL_MASK;
          4'h8: next_st.control3b = st.wDataHeld & COUNTER3_CONTROL_B_MASK;
          4'h2, 4'h4, 4'h6, 4'h9:
          begin
            valIdx = (idx == 4'h9) ? 4'h3 : ((idx >> 1) - 4'h1);
            next_st.preload[valIdx[1:0]] = st.wDataHeld;
            // stopped counter loads at once; running waits overflow
            if (!st.control[valIdx[1:0]][RUN_BIT])
            begin
              next_st.count[valIdx[1:0]] = st.wDataHeld;
            end
          end
          default: ;
        endcase
      end
    end
    next_st.awready = !next_st.awHeld && !next_st.bvalid;
    next_st.wready = !next_st.wHeld && !next_st.bvalid;

    // bus read channel
    if (rvalid && rready)
    begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
    if (arvalid && st.arready)
    begin
      idx = regIndex(araddr);
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = (idx == 4'hF) ? RESP_SLVERR : RESP_OKAY;
      // value registers read the live count
      unique case (idx)
        4'h0: next_st.rdata = {5'h00, st.prescalerControl};
        4'h1: next_st.rdata = st.control[0];
        4'h2: next_st.rdata = st.count[0];
        4'h3: next_st.rdata = st.control[1];
        4'h4: next_st.rdata = st.count[1];
        4'h5: next_st.rdata = st.control[2];
        4'h6: next_st.rdata = st.count[2];
        4'h7: next_st.rdata = st.control[3];
        4'h8: next_st.rdata = st.control3b;
        4'h9: next_st.rdata = st.count[3];
        default: next_st.rdata = 8'h00;
      endcase
    end

    // synchronous reset to defined state
    if (reset)
    begin
      next_st = '0;
      next_st.prescalerControl = PRESCALER_CONTROL_RESET;
      next_st.control[0] = COUNTER_CONTROL_RESET;
      next_st.control[1] = COUNTER_CONTROL_RESET;
      next_st.control[2] = COUNTER2_CONTROL_RESET;
      next_st.control[3] = COUNTER_CONTROL_RESET;
      next_st.control3b = COUNTER3_CONTROL_B_RESET;
      next_st.preload = {4{PRELOAD_RESET}};
      next_st.count = {4{COUNTER_VALUE_RESET}};
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.arready = 1'b1;
    end
  end

  // state register
  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end

  // outputs straight from flip-flops
  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = {24'h000000, st.rdata};
  assign overflowRequest = st.overflowRequest;
  assign triggerBlock = st.triggerBlock;
  assign pulseGenRetrigger = st.pulseGenRetrigger;

endmodule : timer_event_counter_set

`default_nettype wire

// ==== rtl/timer_set_pkg.sv ====
package timer_set_pkg;

  // register byte addresses on the bus
  localparam logic [5:0] ADDR_PRESCALER_CONTROL = 6'h00;
  localparam logic [5:0] ADDR_COUNTER0_CONTROL = 6'h04;
  localparam logic [5:0] ADDR_COUNTER0_VALUE = 6'h08;
  localparam logic [5:0] ADDR_COUNTER1_CONTROL = 6'h0C;
  localparam logic [5:0] ADDR_COUNTER1_VALUE = 6'h10;
  localparam logic [5:0] ADDR_COUNTER2_CONTROL = 6'h14;
  localparam logic [5:0] ADDR_COUNTER2_VALUE = 6'h18;
  localparam logic [5:0] ADDR_COUNTER3_CONTROL_A = 6'h1C;
  localparam logic [5:0] ADDR_COUNTER3_CONTROL_B = 6'h20;
  localparam logic [5:0] ADDR_COUNTER3_VALUE = 6'h24;

  // prescaler control fields
  localparam int PRESCALE_GATE_BIT = 2;
  localparam int PRESCALE_SOURCE_LSB = 0;
  localparam logic [2:0] PRESCALER_CONTROL_RESET = 3'h0;
  localparam logic [1:0] SOURCE_SYS = 2'h0;
  localparam logic [1:0] SOURCE_SYS_DIV4 = 2'h1;
  localparam logic [1:0] SOURCE_SYS_DIV2 = 2'h2;
  localparam logic [1:0] SOURCE_SUB = 2'h3;

  // counter control fields
  localparam int MODE_LSB = 6;
  localparam int EXT_SOURCE_BIT = 5;
  localparam int RUN_BIT = 4;
  localparam int EDGE_SELECT_BIT = 3;
  localparam int RATE_LSB = 0;
  localparam int RETRIGGER_OPTION_BIT = 0;
  localparam logic [7:0] COUNTER_CONTROL_RESET = 8'h08;
  localparam logic [7:0] COUNTER2_CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNTER2_CONTROL_MASK = 8'hD7;
  localparam logic [7:0] COUNTER3_CONTROL_B_RESET = 8'h00;
  localparam logic [7:0] COUNTER3_CONTROL_B_MASK = 8'hC1;
  localparam logic [7:0] COUNTER_VALUE_RESET = 8'h00;
  localparam logic [7:0] PRELOAD_RESET = 8'h00;
  localparam logic [7:0] COUNT_FULL = 8'hFF;

  // operating mode codes
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_PULSE_WIDTH = 2'h3;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : timer_set_pkg
